// ### common/sbc_defines.vh
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH

// ==========================================================
// Timing
// ==========================================================
`define SBC_CLK_PERIOD_NS   100
`define SBC_RESET_MIN_NS    10000
`define SBC_MGMT_INIT_NS    2000
// Least times round up to whole cycles
`define SBC_RESET_MIN_CYC   ((`SBC_RESET_MIN_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)
`define SBC_MGMT_INIT_CYC   ((`SBC_MGMT_INIT_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)

// ==========================================================
// Memory map offsets
// ==========================================================
`define SBC_ADDR_STATUS     8'h00
`define SBC_ADDR_FLAGS      8'h01
`define SBC_ADDR_FAULTS     8'h02
`define SBC_ADDR_CONTROL    8'h03
`define SBC_ADDR_CHAN_DIS   8'h04

// ==========================================================
// Field positions and reset values
// ==========================================================
`define SBC_STATUS_DNR_BIT  0
`define SBC_STATUS_LP_BIT   1
`define SBC_STATUS_SW_BIT   2
`define SBC_FLAGS_RDONE_BIT 0
`define SBC_CTRL_HPEN_BIT   0
`define SBC_CONTROL_RST     8'h00
`define SBC_CHAN_DIS_RST    8'h00

`endif

// ### rtl/sbc_low_filter.v
`timescale 1ns/1ps
// ==========================================================
// Long-low detector for an active-low input
// ==========================================================
module sbc_low_filter #(
    parameter LIMIT = 100,
    parameter CW    = 16
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst,
    // Input level and result
    input  wire          level_n,
    output wire          long_low
);
    reg  [CW-1:0] cnt_q;
    wire [CW-1:0] lim = LIMIT[CW-1:0];

    // Count consecutive low samples, saturating at the limit
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= {CW{1'b0}};
        end else if (level_n) begin
            cnt_q <= {CW{1'b0}};
        end else if (cnt_q != lim) begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // Current low sample plus LIMIT earlier ones: strictly longer than the minimum
    assign long_low = ~level_n & (cnt_q == lim);
endmodule // sbc_low_filter

// ### rtl/sbc_flag_bank.v
`timescale 1ns/1ps
// ==========================================================
// Sticky flag bank, write-one-to-clear, set wins
// ==========================================================
module sbc_flag_bank #(
    parameter W = 9
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst,
    // Events and clears
    input  wire [W-1:0]  set,
    input  wire [W-1:0]  clr,
    input  wire          clr_all,
    // Flag state
    output reg  [W-1:0]  flags_q
);
    // An event in the clearing cycle is kept, never lost
    always @(posedge clk) begin
        if (rst) begin
            flags_q <= {W{1'b0}};
        end else if (clr_all) begin
            flags_q <= set;
        end else begin
            flags_q <= (flags_q & ~clr) | set;
        end
    end
endmodule // sbc_flag_bank

// ### rtl/sbc_sideband_ctrl.v
// Operation
// [R1] Management accesses are answered only while module select is held low.
// [R2] Host gives each module on a shared bus its own select line.
// [R3] Reset pin low longer than the minimum pulse restores all defaults.
// [R4] Host ignores status bits until the reset completion is signalled.
// [R5] Reset completion raises the interrupt with data-not-ready reading negated.
// [R6] Power-up raises the completion interrupt without any reset pulse.
// [R7] Init-mode input is pulled up internally, so undriven means software control.
// [R8] Init-mode high keeps low power until software enables high power.
// [R9] Init-mode low moves to high power once management init finishes.
// [R10] Host holds the init-mode level constant while the module is present.
// [R11] Presence line is tied to ground whenever the module is inserted.
// [R12] Open-collector interrupt goes low for faults or critical status.
// [R13] Host reads the memory map to find the interrupt source.
// [R14] Each channel is addressable and can be switched off individually.
// [R15] Interrupt stays asserted until every pending flag has been cleared.
`timescale 1ns/1ps
`include "sbc_defines.vh"

module sbc_sideband_ctrl #(
    parameter NCH       = 8,
    parameter RST_CYC   = `SBC_RESET_MIN_CYC,
    parameter INIT_CYC  = `SBC_MGMT_INIT_CYC,
    parameter CW        = 16
) (
    // Clock and reset
    input  wire             CLK,
    input  wire             RST,
    // Host sideband inputs
    input  wire             MODULE_SELECT_N,
    input  wire             MODULE_RESET_N,
    input  wire             INIT_CONTROL_SELECT,
    input  wire             INIT_CONTROL_SELECT_DRIVEN,
    // Open-drain sideband outputs
    output wire             MODULE_PRESENT_N_O,
    output wire             MODULE_PRESENT_N_OE,
    output wire             INTERRUPT_N_O,
    output wire             INTERRUPT_N_OE,
    // Management access from the two-wire target
    input  wire             MGMT_REQ,
    input  wire             MGMT_WR,
    input  wire [7:0]       MGMT_ADDR,
    input  wire [7:0]       MGMT_WDATA,
    output reg              MGMT_ACK,
    output reg  [7:0]       MGMT_RDATA,
    // Channel events and controls
    input  wire [NCH-1:0]   CHANNEL_FAULT,
    output reg  [NCH-1:0]   CHANNEL_ENABLE,
    output reg              LOW_POWER_SELECT,
    output reg              DATA_NOT_READY
);

    // ==========================================================
    // States
    // ==========================================================
    // Pin reset hold, init count-up, low power, high power
    localparam ST_RESET = 2'd0;
    localparam ST_INIT  = 2'd1;
    localparam ST_LOW   = 2'd2;
    localparam ST_HIGH  = 2'd3;

    // ==========================================================
    // Address decode helper
    // ==========================================================
    // Exact match of an offset against one map entry
    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // ==========================================================
    // Declarations
    // ==========================================================
    // Sequencer state and init counter
    reg  [1:0]      state_q;
    reg  [1:0]      state_d;
    reg  [CW-1:0]   init_cnt_q;
    reg  [CW-1:0]   init_cnt_d;
    // Host-written settings, latched strap and reset-done strobe
    reg  [7:0]      control_q;
    reg  [NCH-1:0]  chan_dis_q;
    reg             sw_mode_q;
    reg             rdone_set;
    // Qualified pin levels and access strobes
    wire            pin_reset;
    wire            init_mode;
    wire            access;
    wire            wr_en;
    // Sticky flag bank wiring
    wire [NCH:0]    flag_set;
    wire [NCH:0]    flag_clr;
    wire [NCH:0]    flags;
    // Derived control bit and last init count value
    wire            hp_enable;
    wire [CW-1:0]   init_last;

    // Last count value; init lasts INIT_CYC cycles from entry
    assign init_last = INIT_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

    // ==========================================================
    // Reset pin qualification
    // ==========================================================
    // Short glitches on the reset pin are ignored by design
    sbc_low_filter #(
        .LIMIT   (RST_CYC),
        .CW      (CW)
    ) u_rst_filter (
        .clk     (CLK),
        .rst     (RST),
        .level_n (MODULE_RESET_N),
        .long_low(pin_reset)
    );

    // ==========================================================
    // Pin-level behaviour
    // ==========================================================
    // Undriven init-mode input reads high
    assign init_mode = INIT_CONTROL_SELECT_DRIVEN ? INIT_CONTROL_SELECT : 1'b1; // [R7]

    // Presence is a hard ground path while inserted
    assign MODULE_PRESENT_N_O  = 1'b0;            // [R11]
    assign MODULE_PRESENT_N_OE = 1'b1;            // [R11]

    // Open collector: only ever pulls low, released otherwise
    assign INTERRUPT_N_O  = 1'b0;
    assign INTERRUPT_N_OE = |flags;               // [R12] [R15]

    // ==========================================================
    // Management access gating
    // ==========================================================
    // Traffic is seen only with select low and the core out of reset
    // A held request is taken again on every cycle
    assign access = MGMT_REQ & ~MODULE_SELECT_N & (state_q != ST_RESET); // [R1]
    assign wr_en  = access & MGMT_WR;

    // ==========================================================
    // Sticky flags: bit 0 reset done, upper bits channel faults
    // ==========================================================
    // Faults of channels switched off are not reported
    assign flag_set = {CHANNEL_FAULT & ~chan_dis_q, rdone_set};            // [R12]
    // Clears land only on a taken write
    assign flag_clr = {wr_en && hit(MGMT_ADDR, `SBC_ADDR_FAULTS) ?
                           MGMT_WDATA[NCH-1:0] : {NCH{1'b0}},
                       wr_en && hit(MGMT_ADDR, `SBC_ADDR_FLAGS) &
                           MGMT_WDATA[`SBC_FLAGS_RDONE_BIT]};              // [R15]

    // Pin reset wipes the bank; an event in that cycle survives
    sbc_flag_bank #(
        .W       (NCH + 1)
    ) u_flags (
        .clk     (CLK),
        .rst     (RST),
        .set     (flag_set),
        .clr     (flag_clr),
        .clr_all (pin_reset),
        .flags_q (flags)
    );

    // ==========================================================
    // Control and channel registers
    // ==========================================================
    // A qualified pin reset returns every setting to its default
    always @(posedge CLK) begin
        if (RST || pin_reset) begin
            control_q  <= `SBC_CONTROL_RST;                  // [R3]
            chan_dis_q <= `SBC_CHAN_DIS_RST;                 // [R3]
        // Refused writes never get this far
        end else if (wr_en) begin
            if (hit(MGMT_ADDR, `SBC_ADDR_CONTROL)) begin
                control_q <= MGMT_WDATA;
            end
            if (hit(MGMT_ADDR, `SBC_ADDR_CHAN_DIS)) begin
                chan_dis_q <= MGMT_WDATA[NCH-1:0];           // [R14]
            end
        end
    end

    // Software permission to leave low power
    assign hp_enable = control_q[`SBC_CTRL_HPEN_BIT];

    // ==========================================================
    // Power and initialisation sequencer
    // ==========================================================
    // Power-up enters init directly, so completion is posted unasked
    always @* begin
        state_d    = state_q;
        init_cnt_d = init_cnt_q;
        rdone_set  = 1'b0;
        case (state_q)
            ST_RESET: begin
                // Held here for as long as the pin stays low
                init_cnt_d = {CW{1'b0}};
                if (MODULE_RESET_N) begin
                    state_d = ST_INIT;
                end
            end
            ST_INIT: begin
                if (init_cnt_q == init_last) begin
                    rdone_set = 1'b1;                        // [R5] [R6]
                    if (init_mode) begin
                        state_d = ST_LOW;                    // [R8]
                    end else begin
                        state_d = ST_HIGH;                   // [R9]
                    end
                end else begin
                    init_cnt_d = init_cnt_q + {{(CW-1){1'b0}}, 1'b1};
                end
            end
            ST_LOW: begin
                // Hardware mode never waits for software
                if (!sw_mode_q || hp_enable) begin
                    state_d = ST_HIGH;                       // [R8]
                end
            end
            ST_HIGH: begin
                // Software may drop back to low power in its own mode
                if (sw_mode_q && !hp_enable) begin
                    state_d = ST_LOW;                        // [R8]
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
        // A qualified pin reset overrides every state
        if (pin_reset) begin
            state_d = ST_RESET;                              // [R3]
        end
    end

    // State, counter and latched init mode
    always @(posedge CLK) begin
        if (RST) begin
            state_q    <= ST_INIT;                           // [R6]
            init_cnt_q <= {CW{1'b0}};
            sw_mode_q  <= 1'b1;
        end else begin
            state_q    <= state_d;
            init_cnt_q <= init_cnt_d;
            // Host keeps the level steady, so one sample per init suffices
            if (state_q == ST_INIT && state_d != ST_INIT) begin
                sw_mode_q <= init_mode;                      // [R10]
            end
        end
    end

    // ==========================================================
    // Status outputs
    // ==========================================================
    // Data-not-ready stays set until the cycle completion is flagged
    always @(posedge CLK) begin
        if (RST) begin
            DATA_NOT_READY   <= 1'b1;
            LOW_POWER_SELECT <= 1'b1;
            CHANNEL_ENABLE   <= {NCH{1'b0}};
        end else begin
            // Driven from the next state, so they move with it
            DATA_NOT_READY   <= (state_d == ST_RESET) || (state_d == ST_INIT); // [R5]
            LOW_POWER_SELECT <= (state_d != ST_HIGH);        // [R8] [R9]
            // Channels run only in high power and when not switched off
            CHANNEL_ENABLE   <= (state_d == ST_HIGH) ?
                                ~chan_dis_q : {NCH{1'b0}};   // [R14]
        end
    end

    // ==========================================================
    // Management read path
    // ==========================================================
    // One-cycle answer; unmapped offsets read as zero
    always @(posedge CLK) begin
        if (RST) begin
            MGMT_ACK   <= 1'b0;
            MGMT_RDATA <= 8'h00;
        end else begin
            // Ack every taken access, reads and writes alike
            MGMT_ACK <= access;                              // [R1]
            if (access && !MGMT_WR) begin
                MGMT_RDATA <= 8'h00;
                // Offsets are exclusive, so at most one branch fires
                if (hit(MGMT_ADDR, `SBC_ADDR_STATUS)) begin
                    MGMT_RDATA[`SBC_STATUS_DNR_BIT] <= DATA_NOT_READY; // [R5]
                    MGMT_RDATA[`SBC_STATUS_LP_BIT]  <= LOW_POWER_SELECT;
                    MGMT_RDATA[`SBC_STATUS_SW_BIT]  <= sw_mode_q;
                end
                if (hit(MGMT_ADDR, `SBC_ADDR_FLAGS)) begin
                    MGMT_RDATA[`SBC_FLAGS_RDONE_BIT] <= flags[0];      // [R13]
                end
                if (hit(MGMT_ADDR, `SBC_ADDR_FAULTS)) begin
                    MGMT_RDATA[NCH-1:0] <= flags[NCH:1];            // [R13]
                end
                if (hit(MGMT_ADDR, `SBC_ADDR_CONTROL)) begin
                    MGMT_RDATA <= control_q;
                end
                if (hit(MGMT_ADDR, `SBC_ADDR_CHAN_DIS)) begin
                    MGMT_RDATA[NCH-1:0] <= chan_dis_q;              // [R14]
                end
            end
        end
    end

endmodule // sbc_sideband_ctrl

// ### tb/sbc_chk.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for sideband control
// ==========================================
module sbc_chk #(
    parameter NCH = 8
) (
    // Clock and reset
    input wire           CLK,
    input wire           RST,
    // Host inputs
    input wire           MODULE_SELECT_N,
    input wire           MODULE_RESET_N,
    input wire           INIT_CONTROL_SELECT,
    input wire           INIT_CONTROL_SELECT_DRIVEN,
    // Open-drain outputs
    input wire           MODULE_PRESENT_N_O,
    input wire           MODULE_PRESENT_N_OE,
    input wire           INTERRUPT_N_O,
    input wire           INTERRUPT_N_OE,
    // Management port
    input wire           MGMT_REQ,
    input wire           MGMT_WR,
    input wire [7:0]     MGMT_ADDR,
    input wire [7:0]     MGMT_WDATA,
    input wire           MGMT_ACK,
    input wire [7:0]     MGMT_RDATA,
    // Channels and status
    input wire [NCH-1:0] CHANNEL_FAULT,
    input wire [NCH-1:0] CHANNEL_ENABLE,
    input wire           LOW_POWER_SELECT,
    input wire           DATA_NOT_READY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Reset pin low long enough; bench runs with a 3-cycle minimum
    sequence long_low;
        !MODULE_RESET_N [*4];
    endsequence
    // Too short to count, must leave no trace
    sequence short_low;
        MODULE_RESET_N ##1 !MODULE_RESET_N [*3] ##1 MODULE_RESET_N;
    endsequence
    AST_PRESENT: assert property (MODULE_PRESENT_N_OE && !MODULE_PRESENT_N_O)
        else $error("present line not sunk");
    AST_INT_SINK: assert property (INTERRUPT_N_OE |-> !INTERRUPT_N_O)
        else $error("interrupt not driven low");
    AST_REFUSE: assert property (!MGMT_REQ || MODULE_SELECT_N |=> !MGMT_ACK)
        else $error("ack without selected request");
    AST_TAKE: assert property (MGMT_REQ && !MODULE_SELECT_N && MODULE_RESET_N
        && $past(MODULE_RESET_N) && $past(MODULE_RESET_N, 2) |=> MGMT_ACK)
        else $error("selected request not answered");
    AST_DONE_INT: assert property ($fell(DATA_NOT_READY) |-> INTERRUPT_N_OE)
        else $error("ready without interrupt");
    AST_POWER_UP: assert property ($fell(RST) |-> ##[1:8] INTERRUPT_N_OE)
        else $error("no completion interrupt at power-up");
    AST_LONG_RESET: assert property (long_low |-> ##2 DATA_NOT_READY
        && LOW_POWER_SELECT && CHANNEL_ENABLE == '0)
        else $error("long reset pulse not honoured");
    AST_SHORT_PULSE: assert property (!DATA_NOT_READY ##0 short_low
        |=> !DATA_NOT_READY [*3])
        else $error("short reset pulse acted");
    AST_INT_HOLD: assert property ($fell(INTERRUPT_N_OE)
        |-> MGMT_ACK || !$past(MODULE_RESET_N))
        else $error("interrupt released without clear");
    AST_CHAN_LP: assert property (CHANNEL_ENABLE != '0 |-> !LOW_POWER_SELECT)
        else $error("channel on in low power");
endmodule // sbc_chk

// ### tb/sbc_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host board: pull-ups and mode strap
// ==========================================
module sbc_host_model (
    // Clock
    input  wire clk,
    // Strap choice of the host
    input  wire strap_drive,
    input  wire strap_level,
    // Open-drain pins from the module
    input  wire pres_o,
    input  wire pres_oe,
    input  wire int_o,
    input  wire int_oe,
    // Strap seen by module, board line levels
    output reg  init_pin,
    output wire init_driven,
    output wire present_line_n,
    output wire interrupt_line_n
);
    reg toggle_q = 1'b0;
    // Undriven strap wanders; only the module pull-up may decide
    always @(posedge clk) begin
        toggle_q <= ~toggle_q;
    end
    // Driven level only changes across a re-insertion; undriven it toggles every cycle
    always @* begin
        init_pin = strap_drive ? strap_level : toggle_q;
    end
    assign init_driven = strap_drive;
    // Board pull-ups: high unless the module sinks the line
    assign present_line_n   = (pres_oe && !pres_o) ? 1'b0 : 1'b1;
    assign interrupt_line_n = (int_oe && !int_o) ? 1'b0 : 1'b1;
endmodule // sbc_host_model

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "sbc_defines.vh"
// ==========================================
// Self-checking bench for sideband control
// ==========================================
module testbench;
    localparam NCH = 8;
    reg            clk = 1'b0;
    reg            rst = 1'b1;
    reg            sel_n = 1'b0; // Own select line for this module
    reg            rst_n = 1'b1;
    reg            s_drv = 1'b0;
    reg            s_lvl = 1'b1;
    reg            req = 1'b0;
    reg            wr = 1'b0;
    reg  [7:0]     addr = 8'h00;
    reg  [7:0]     wdata = 8'h00;
    reg  [NCH-1:0] fault = '0;
    wire           i_pin, i_drv, p_o, p_oe, i_o, i_oe, p_line, i_line, ack, lp, dnr;
    wire [7:0]     rdata;
    wire [NCH-1:0] ch_en;
    integer        failures = 0;
    integer        total_checks = 0;
    reg  [8:0]     notes [$];
    reg  [8:0]     e;
    reg  [7:0]     d;
    integer        c;
    always #50 clk = ~clk;
    // ==========================================
    // Design and host board
    // ==========================================
    sbc_sideband_ctrl #(.NCH(NCH), .RST_CYC(3), .INIT_CYC(2)) DUT (
        .CLK(clk), .RST(rst), .MODULE_SELECT_N(sel_n), .MODULE_RESET_N(rst_n),
        .INIT_CONTROL_SELECT(i_pin), .INIT_CONTROL_SELECT_DRIVEN(i_drv),
        .MODULE_PRESENT_N_O(p_o), .MODULE_PRESENT_N_OE(p_oe),
        .INTERRUPT_N_O(i_o), .INTERRUPT_N_OE(i_oe), .MGMT_REQ(req), .MGMT_WR(wr),
        .MGMT_ADDR(addr), .MGMT_WDATA(wdata), .MGMT_ACK(ack), .MGMT_RDATA(rdata),
        .CHANNEL_FAULT(fault), .CHANNEL_ENABLE(ch_en), .LOW_POWER_SELECT(lp),
        .DATA_NOT_READY(dnr));
    sbc_host_model u_host (.clk(clk), .strap_drive(s_drv), .strap_level(s_lvl),
        .pres_o(p_o), .pres_oe(p_oe), .int_o(i_o), .int_oe(i_oe), .init_pin(i_pin),
        .init_driven(i_drv), .present_line_n(p_line), .interrupt_line_n(i_line));
    // ==========================================
    // Tasks
    // ==========================================
    task chk(input string what, input [7:0] exp, input [7:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Request stays up across back-to-back calls; refused ones leave no note
    task acc(input w, input [7:0] a, input [7:0] v, input [7:0] exp);
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= v;
        if (!sel_n && rst_n)
            notes.push_back({!w, exp});
    endtask
    task idle(input integer n);
        repeat (n) begin
            @(posedge clk);
            req <= 1'b0;
        end
        #1;
    endtask
    task wait_ready;
        integer k;
        for (k = 0; k < 60 && dnr !== 1'b0; k = k + 1) begin
            @(posedge clk);
            #1;
        end
        if (dnr !== 1'b0) begin
            failures = failures + 1;
            wrap_up;
        end
    endtask
    // Strap changes only while the module is held as if unplugged
    task power_up(input drv, input lvl);
        @(posedge clk);
        rst <= 1'b1;
        s_drv <= drv;
        s_lvl <= lvl;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wait_ready;
    endtask
    // Watcher: each ack takes the oldest note; read notes hold the byte
    always @(posedge clk) begin
        if (ack === 1'b1) begin
            if (notes.size() == 0)
                chk("ack_note", 8'h00, 8'h01);
            else begin
                e = notes.pop_front();
                if (e[8])
                    chk("rdata", e[7:0], rdata);
            end
        end
    end
    // ==========================================
    // Scenarios
    // ==========================================
    initial begin
        d = $urandom(32'h5128);
        power_up(1'b0, 1'b1);
        chk("int_line", 8'h00, {7'h00, i_line});
        chk("pres_line", 8'h00, {7'h00, p_line});
        chk("lp", 8'h01, {7'h00, lp});
        acc(0, `SBC_ADDR_STATUS, 8'h00, 8'h06);
        acc(0, `SBC_ADDR_FLAGS, 8'h00, 8'h01);
        acc(1, 8'h55, 8'hA5, 8'h00);
        acc(0, 8'h55, 8'h00, 8'h00);
        // Deselected clear must not land
        idle(1);
        sel_n <= 1'b1;
        acc(1, `SBC_ADDR_FLAGS, 8'h01, 8'h00);
        idle(1);
        sel_n <= 1'b0;
        acc(0, `SBC_ADDR_FLAGS, 8'h00, 8'h01);
        acc(1, `SBC_ADDR_FLAGS, 8'h01, 8'h00);
        idle(2);
        chk("int_line", 8'h01, {7'h00, i_line});
        // Random disable mask, two channels kept on
        c = $urandom % NCH;
        d = $urandom;
        d[c] = 1'b0;
        d[(c + 1) % NCH] = 1'b0;
        acc(1, `SBC_ADDR_CHAN_DIS, d, 8'h00);
        acc(1, `SBC_ADDR_CONTROL, 8'h01, 8'h00);
        acc(0, `SBC_ADDR_CHAN_DIS, 8'h00, d);
        idle(4);
        chk("ch_en", ~d, ch_en);
        chk("lp", 8'h00, {7'h00, lp});
        acc(0, `SBC_ADDR_STATUS, 8'h00, 8'h04);
        idle(1);
        // Fault on every channel; only enabled ones may flag
        fault <= {NCH{1'b1}};
        @(posedge clk) fault <= '0;
        idle(2);
        chk("int_line", 8'h00, {7'h00, i_line});
        acc(0, `SBC_ADDR_FAULTS, 8'h00, ~d);
        acc(1, `SBC_ADDR_FAULTS, 8'h01 << c, 8'h00);
        idle(2);
        chk("int_line", 8'h00, {7'h00, i_line});
        acc(1, `SBC_ADDR_FAULTS, ~d, 8'h00);
        idle(2);
        chk("int_line", 8'h01, {7'h00, i_line});
        // Short reset pulse keeps settings
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        acc(0, `SBC_ADDR_CONTROL, 8'h00, 8'h01);
        // Software steps back to low power, then up again
        acc(1, `SBC_ADDR_CONTROL, 8'h00, 8'h00);
        idle(3);
        chk("lp", 8'h01, {7'h00, lp});
        chk("ch_en", 8'h00, ch_en);
        acc(1, `SBC_ADDR_CONTROL, 8'h01, 8'h00);
        idle(1);
        // Long pulse restores defaults; access during hold refused
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        acc(0, `SBC_ADDR_STATUS, 8'h00, 8'h00);
        idle(1);
        rst_n <= 1'b1;
        idle(1);
        wait_ready;
        chk("int_line", 8'h00, {7'h00, i_line});
        chk("ch_en", 8'h00, ch_en);
        acc(0, `SBC_ADDR_CONTROL, 8'h00, `SBC_CONTROL_RST);
        acc(0, `SBC_ADDR_CHAN_DIS, 8'h00, `SBC_CHAN_DIS_RST);
        acc(0, `SBC_ADDR_FLAGS, 8'h00, 8'h01);
        idle(1);
        // Hardware-controlled start goes straight to high power
        power_up(1'b1, 1'b0);
        idle(2);
        chk("lp", 8'h00, {7'h00, lp});
        chk("ch_en", 8'hFF, ch_en);
        acc(0, `SBC_ADDR_STATUS, 8'h00, 8'h00);
        idle(3);
        chk("notes_left", 8'h00, notes.size());
        wrap_up;
    end
endmodule // testbench

bind sbc_sideband_ctrl sbc_chk #(.NCH(NCH)) u_chk (
    .CLK(CLK), .RST(RST), .MODULE_SELECT_N(MODULE_SELECT_N),
    .MODULE_RESET_N(MODULE_RESET_N), .INIT_CONTROL_SELECT(INIT_CONTROL_SELECT),
    .INIT_CONTROL_SELECT_DRIVEN(INIT_CONTROL_SELECT_DRIVEN),
    .MODULE_PRESENT_N_O(MODULE_PRESENT_N_O), .MODULE_PRESENT_N_OE(MODULE_PRESENT_N_OE),
    .INTERRUPT_N_O(INTERRUPT_N_O), .INTERRUPT_N_OE(INTERRUPT_N_OE),
    .MGMT_REQ(MGMT_REQ), .MGMT_WR(MGMT_WR), .MGMT_ADDR(MGMT_ADDR),
    .MGMT_WDATA(MGMT_WDATA), .MGMT_ACK(MGMT_ACK), .MGMT_RDATA(MGMT_RDATA),
    .CHANNEL_FAULT(CHANNEL_FAULT), .CHANNEL_ENABLE(CHANNEL_ENABLE),
    .LOW_POWER_SELECT(LOW_POWER_SELECT), .DATA_NOT_READY(DATA_NOT_READY));
